// ---- hdl/bus_phase_gen.sv ----
// Divider that forms the two bus clock phases and phase enables
`timescale 1ns/1ps
module bus_phase_gen (
   input wire logic sys_clk_i, // System clock
   input wire logic rst_b_i, // Async reset, active low
   output logic [1:0] phase_o, // Position within the bus clock period
   output logic phase_a_o, // Bus clock phase a
   output logic phase_b_o, // Bus clock phase b
   output logic period_end_o // Pulse on last system clock of a period
);
   logic [1:0] phase_ff;

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         phase_ff <= lbus_pkg::PHASE_RST;
      end else begin
         phase_ff <= phase_ff + 2'h1;
      end
   end

   assign phase_o = phase_ff;
   assign phase_a_o = (phase_ff < lbus_pkg::PHASE_B_START);
   assign phase_b_o = (phase_ff >= lbus_pkg::PHASE_B_START);
   assign period_end_o = (phase_ff == lbus_pkg::PHASE_LAST);
endmodule

// ---- hdl/byte_parity.sv ----
// Odd parity generator and checker for a 16-bit word
`timescale 1ns/1ps
module byte_parity (
   input wire logic [15:0] data_i, // Word to protect
   input wire logic [1:0] par_i, // Received parity bits
   output logic [1:0] par_o, // Generated parity, one per byte
   output logic err_o // Mismatch on any byte
);
   function automatic logic odd_par(input logic [7:0] b);
      return ~^b;
   endfunction

   always_comb begin
      par_o[0] = odd_par(data_i[7:0]);
      par_o[1] = odd_par(data_i[15:8]);
      err_o = (par_o != par_i);
   end
endmodule

// ---- hdl/lbus_pkg.sv ----
// Shared constants and carriers for the local bus wait-state controller
package lbus_pkg;
   // Bus clock period in system clocks (phase a then phase b)
   localparam int unsigned BUS_PERIOD_CYC = 4;
   localparam logic [1:0] PHASE_LAST = 2'h3;
   // Phase point at which ready is sampled (inside phase b)
   localparam logic [1:0] READY_SAMPLE_PHASE = 2'h2;
   // Half-period boundary between phase a and phase b
   localparam logic [1:0] PHASE_B_START = 2'h2;
   localparam logic [1:0] PHASE_RST = 2'h0;
   // Memory map
   localparam logic [15:0] EXP_RAM_BASE = 16'h4000;
   localparam logic [15:0] EXP_RAM_SIZE = 16'h4000;
   localparam logic [15:0] PROG_BASE = 16'hc000;
   localparam int unsigned TOP_ADDR_POS = 15;
   localparam logic [7:0] WAIT_CNT_RST = 8'h00;

   typedef enum logic [1:0] {
      ROLE_CP_MASTER,
      ROLE_PH_MASTER,
      ROLE_EXT_MASTER_PH,
      ROLE_CP_INTERNAL
   } role_t;

   // A request from the owning master
   typedef struct packed {
      logic valid;
      logic rd_not_wr;
      logic [14:0] addr;
      logic [15:0] wdata;
      role_t role;
   } bus_req_t;

   // The completed access
   typedef struct packed {
      logic done;
      logic [15:0] rdata;
      logic par_err;
   } bus_rsp_t;
endpackage

// ---- hdl/local_bus_wait_state_control.sv ----
// Local bus cycle sequencer with ready-driven wait states and byte parity
`timescale 1ns/1ps
module local_bus_wait_state_control (
   input wire logic sys_clk_i, // System clock, 40 MHz
   input wire logic rst_b_i, // Async reset, active low
   input wire lbus_pkg::bus_req_t req_i, // Access request from the master
   output lbus_pkg::bus_rsp_t rsp_o, // Completion, read data, parity error
   output logic req_ready_o, // Sequencer idle, request taken
   input wire logic ext_rom_sel_i, // Strap: external EPROM replaces handler ROM
   output logic int_rom_en_o, // Handler ROM enable
   input wire logic irq_i, // Interrupt request to processor
   input wire logic bus_req_i, // Bus request from another master
   output logic irq_take_o, // Interrupt accepted, pulse
   output logic bus_grant_o, // Bus request granted, level
   output logic hold_state_o, // Processor must freeze its state
   input wire logic local_bus_ready_n_i, // Ready line level
   output logic local_bus_ready_n_o, // Ready drive, always low when enabled
   output logic local_bus_ready_n_oe_o, // Ready open-drain pull enable
   input wire logic slow_slave_wait_i, // Own slave logic asks for a wait
   output logic [15:0] addr_o, // Address on bus
   output logic [1:0] addr_par_o, // Address parity
   output logic [15:0] data_o, // Data driven on bus
   output logic [1:0] data_par_o, // Data parity driven
   output logic data_oe_o, // Data drive enable
   input wire logic [15:0] data_i, // Data read from bus
   input wire logic [1:0] data_par_i, // Parity read from bus
   output logic local_read_not_write_o, // Read high, write low
   output logic local_bus_enable_strobe_o, // Bus enable, active high
   output logic local_bus_clock_phase_a_o, // Bus clock phase a
   output logic local_bus_clock_phase_b_o, // Bus clock phase b
   output logic exp_ram_cs_n_o, // Expansion RAM select, active low
   output logic xcvr_dir_o, // Transceiver direction, high toward bus
   output logic xcvr_en_n_o, // Transceiver enable, active low
   output logic ram_we_n_o, // Expansion RAM write strobe, active low
   output logic [7:0] wait_count_o // Wait states in the current cycle
);
   typedef enum logic [1:0] {IDLE, ACCESS, WAIT} seq_t;

   seq_t state_ff;
   lbus_pkg::bus_req_t cur_ff;
   logic [15:0] rdata_ff;
   logic perr_ff;
   logic done_ff;
   logic [7:0] wait_cnt_ff;
   logic rw_lat_ff;
   logic rom_strap_ff;
   logic irq_take_ff;
   logic grant_ff;
   logic [1:0] phase;
   logic ph_a;
   logic ph_b;
   logic period_end;
   logic sample_pt;
   logic ready_low;
   logic honour;
   logic is_prog;
   logic is_exp_ram;
   logic stretch;
   logic [15:0] bus_addr;
   logic [1:0] rd_par;
   logic rd_err;
   logic [1:0] req_data_par;
   logic stretch_lat;
   logic take;
   logic cycle_end;
   logic [15:0] req_addr;
   logic [1:0] req_addr_par;
   logic [15:0] addr_ff;
   logic [1:0] addr_par_ff;
   logic [1:0] data_par_ff;
   logic strobe_ff;
   logic rnw_ff;

   function automatic logic in_exp_ram(input logic [15:0] a);
      return (a >= lbus_pkg::EXP_RAM_BASE) &&
         (a < lbus_pkg::EXP_RAM_BASE + lbus_pkg::EXP_RAM_SIZE);
   endfunction

   bus_phase_gen u_phase (
      .sys_clk_i(sys_clk_i),
      .rst_b_i(rst_b_i),
      .phase_o(phase),
      .phase_a_o(ph_a),
      .phase_b_o(ph_b),
      .period_end_o(period_end)
   );

   byte_parity u_rd_par (
      .data_i(data_i),
      .par_i(data_par_i),
      .par_o(rd_par),
      .err_o(rd_err)
   );

   byte_parity u_wr_par (
      .data_i(req_i.wdata),
      .par_i(2'h0),
      .par_o(req_data_par),
      .err_o()
   );

   byte_parity u_ad_par (
      .data_i(req_addr),
      .par_i(2'h0),
      .par_o(req_addr_par),
      .err_o()
   );

   assign req_addr = {1'b1, req_i.addr};
   assign bus_addr = {1'b1, cur_ff.addr};
   assign is_exp_ram = in_exp_ram(bus_addr);
   assign is_prog = (bus_addr >= lbus_pkg::PROG_BASE);
   assign sample_pt = (phase == lbus_pkg::READY_SAMPLE_PHASE);
   assign ready_low = ~local_bus_ready_n_i;

   // Whether this cycle may be stretched at all
   always_comb begin
      unique case (cur_ff.role)
         lbus_pkg::ROLE_CP_MASTER: honour = 1'b1;
         lbus_pkg::ROLE_EXT_MASTER_PH: honour = 1'b1;
         lbus_pkg::ROLE_PH_MASTER: honour = 1'b0;
         lbus_pkg::ROLE_CP_INTERNAL: honour = 1'b0;
      endcase
   end

   // Own slave asks for one wait only, and only on program store
   assign local_bus_ready_n_o = 1'b0;
   assign local_bus_ready_n_oe_o = (state_ff == ACCESS) && slow_slave_wait_i &&
      is_prog && !is_exp_ram;

   assign stretch = honour && ready_low && (state_ff != IDLE);

   // Request accepted, and cycle finished, both on a period end
   assign take = req_ready_o && req_i.valid;
   assign cycle_end = period_end && (state_ff != IDLE) && !stretch_lat;

   // Cycle sequencer, aligned to bus clock periods
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_ff <= IDLE;
      end else if (period_end) begin
         unique case (state_ff)
            IDLE: begin
               if (take) begin
                  state_ff <= ACCESS;
               end
            end
            ACCESS: begin
               state_ff <= stretch_lat ? WAIT : IDLE;
            end
            WAIT: begin
               state_ff <= stretch_lat ? WAIT : IDLE;
            end
            default: begin
               state_ff <= IDLE;
            end
         endcase
      end
   end

   // Ready caught at the fixed sample point of each period
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         stretch_lat <= 1'b0;
      end else if (sample_pt) begin
         stretch_lat <= stretch;
      end
   end

   // Request captured at the start of a cycle, held through waits
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cur_ff <= '0;
      end else if (take) begin
         cur_ff <= req_i;
      end
   end

   // Read data taken at the last period of the cycle
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rdata_ff <= 16'h0000;
         perr_ff <= 1'b0;
         done_ff <= 1'b0;
      end else begin
         done_ff <= 1'b0;
         if (cycle_end) begin
            done_ff <= 1'b1;
            if (cur_ff.rd_not_wr) begin
               rdata_ff <= data_i;
               perr_ff <= rd_err;
            end else begin
               perr_ff <= 1'b0;
            end
         end
      end
   end

   // Waits counted per cycle
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wait_cnt_ff <= lbus_pkg::WAIT_CNT_RST;
      end else if (period_end) begin
         if (state_ff == IDLE) begin
            wait_cnt_ff <= lbus_pkg::WAIT_CNT_RST;
         end else if (stretch_lat && wait_cnt_ff != 8'hff) begin
            wait_cnt_ff <= wait_cnt_ff + 8'h01;
         end
      end
   end

   // Direction latched at the end of the first system clock of phase a
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rw_lat_ff <= 1'b1;
      end else if (phase == lbus_pkg::PHASE_RST) begin
         rw_lat_ff <= (state_ff == IDLE) ? 1'b1 : cur_ff.rd_not_wr;
      end
   end

   // Strap sampled again on every system clock after reset release
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rom_strap_ff <= 1'b0;
      end else begin
         rom_strap_ff <= ext_rom_sel_i;
      end
   end

   // Interrupt and bus grant deferred while held
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         irq_take_ff <= 1'b0;
         grant_ff <= 1'b0;
      end else begin
         irq_take_ff <= irq_i && !hold_state_o && !irq_take_ff;
         if (!bus_req_i) begin
            grant_ff <= 1'b0;
         end else if (!hold_state_o && state_ff == IDLE && !take) begin
            grant_ff <= 1'b1;
         end
      end
   end

   assign hold_state_o = (state_ff == WAIT) || stretch;
   assign req_ready_o = (state_ff == IDLE) && period_end && !grant_ff;
   assign irq_take_o = irq_take_ff;
   assign bus_grant_o = grant_ff;
   assign int_rom_en_o = !rom_strap_ff;

   assign rsp_o.done = done_ff;
   assign rsp_o.rdata = rdata_ff;
   assign rsp_o.par_err = perr_ff;
   assign wait_count_o = wait_cnt_ff;

   // Bus pins registered, changing only at cycle boundaries
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         addr_ff <= 16'h0000;
         addr_par_ff <= 2'h3;
         data_par_ff <= 2'h3;
         strobe_ff <= 1'b0;
         rnw_ff <= 1'b1;
      end else if (take) begin
         addr_ff <= req_addr;
         addr_par_ff <= req_addr_par;
         data_par_ff <= req_data_par;
         strobe_ff <= 1'b1;
         rnw_ff <= req_i.rd_not_wr;
      end else if (cycle_end) begin
         addr_ff <= 16'h0000;
         addr_par_ff <= 2'h3;
         strobe_ff <= 1'b0;
         rnw_ff <= 1'b1;
      end
   end

   assign addr_o = addr_ff;
   assign addr_par_o = addr_par_ff;
   assign data_o = cur_ff.wdata;
   assign data_par_o = data_par_ff;
   assign data_oe_o = strobe_ff && !rnw_ff;
   assign local_read_not_write_o = rnw_ff;
   assign local_bus_enable_strobe_o = strobe_ff;
   assign local_bus_clock_phase_a_o = ph_a;
   assign local_bus_clock_phase_b_o = ph_b;

   assign exp_ram_cs_n_o = !(local_bus_enable_strobe_o && is_exp_ram);
   assign xcvr_en_n_o = !(local_bus_enable_strobe_o && is_exp_ram);
   assign xcvr_dir_o = !rw_lat_ff;
   assign ram_we_n_o = !(!rw_lat_ff && ph_a && !exp_ram_cs_n_o);
endmodule

// ---- sim/lbus_asserts.sv ----
// Concurrent checks on the local bus wait-state controller ports
`timescale 1ns/1ps
module lbus_asserts (
   input wire logic sys_clk_i, // Clock
   input wire logic rst_b_i, // Reset, active low
   input wire lbus_pkg::bus_req_t req_i, // Request
   input wire lbus_pkg::bus_rsp_t rsp_o, // Response
   input wire logic req_ready_o, // Request taken
   input wire logic irq_take_o, // Interrupt taken
   input wire logic bus_grant_o, // Bus granted
   input wire logic hold_state_o, // Processor frozen
   input wire logic [15:0] addr_o, // Address
   input wire logic [1:0] addr_par_o, // Address parity
   input wire logic [15:0] data_o, // Write data
   input wire logic [1:0] data_par_o, // Write parity
   input wire logic data_oe_o, // Data drive
   input wire logic local_bus_enable_strobe_o, // Cycle strobe
   input wire logic local_bus_clock_phase_a_o, // Phase a
   input wire logic exp_ram_cs_n_o, // RAM select
   input wire logic xcvr_en_n_o, // Transceiver enable
   input wire logic xcvr_dir_o, // Transceiver direction
   input wire logic ram_we_n_o // RAM write strobe
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);
   logic take;
   logic stb;
   assign take = req_ready_o && req_i.valid && !bus_grant_o;
   assign stb = local_bus_enable_strobe_o;
   top_bit_a: assert property (stb |-> addr_o[15])
      else $error("Top address bit low in a cycle");
   addr_par_a: assert property (stb |-> addr_par_o == {~^addr_o[15:8], ~^addr_o[7:0]})
      else $error("Address parity wrong");
   data_par_a: assert property (data_oe_o |-> data_par_o == {~^data_o[15:8], ~^data_o[7:0]})
      else $error("Write data parity wrong");
   wait_hold_a: assert property (hold_state_o && local_bus_clock_phase_a_o |=>
      $stable(addr_o) && $stable(data_o)) else $error("Bus moved during a wait");
   we_strobe_a: assert property (!ram_we_n_o |-> local_bus_clock_phase_a_o && !exp_ram_cs_n_o)
      else $error("RAM write strobe outside phase a or select");
   xcvr_gate_a: assert property (!xcvr_en_n_o |-> stb)
      else $error("Transceivers enabled without strobe");
   xcvr_dir_a: assert property (!xcvr_en_n_o && !local_bus_clock_phase_a_o &&
      $past(!local_bus_clock_phase_a_o) |-> $stable(xcvr_dir_o)) else $error("Direction moved");
   ph_nowait_a: assert property (take && req_i.role == lbus_pkg::ROLE_PH_MASTER |->
      ##5 rsp_o.done) else $error("Handler master cycle stretched");
   min_len_a: assert property (take |=> !rsp_o.done [*4])
      else $error("Cycle shorter than one bus period");
   irq_defer_a: assert property ($past(hold_state_o) |-> !irq_take_o && !$rose(bus_grant_o))
      else $error("Request accepted while frozen");
   cover property (hold_state_o ##4 hold_state_o);
   cover property (take && !req_i.rd_not_wr);
   cover property (rsp_o.done && rsp_o.par_err);
endmodule
bind local_bus_wait_state_control lbus_asserts CHK (.sys_clk_i, .rst_b_i, .req_i, .rsp_o,
   .req_ready_o, .irq_take_o, .bus_grant_o, .hold_state_o, .addr_o, .addr_par_o, .data_o,
   .data_par_o, .data_oe_o, .local_bus_enable_strobe_o, .local_bus_clock_phase_a_o,
   .exp_ram_cs_n_o, .xcvr_en_n_o, .xcvr_dir_o, .ram_we_n_o);

// ---- sim/lbus_mem_model.sv ----
// Behavioural program store and buffer memory beyond the local bus
`timescale 1ns/1ps
module lbus_mem_model (
   input wire logic sys_clk_i, // Clock
   input wire logic [2:0] waits_i, // Wait periods to ask for
   input wire logic bad_par_i, // Corrupt read parity
   input wire logic [15:0] addr_i, // Bus address
   input wire logic strobe_i, // Cycle strobe
   input wire logic rnw_i, // Read high
   input wire logic phase_b_i, // Phase b
   input wire logic [15:0] wdata_i, // Write data
   output logic [15:0] rdata_o, // Read data
   output logic [1:0] rpar_o, // Read parity
   output logic pull_o // Pulls ready low
);
   logic [15:0] mem [16];
   logic [15:0] last;
   logic [2:0] used;
   logic sb;
   initial begin
      for (int i = 0; i < 16; i++) begin
         mem[i] = 16'h0f00 | 16'(i);
      end
      last = 16'h0000;
      used = 3'h0;
      sb = 1'b0;
   end
   // Program store only, pulled from phase a and let go once per phase b fall
   assign pull_o = strobe_i && addr_i[14] && (used < waits_i);
   always @(posedge sys_clk_i) begin
      sb <= strobe_i && phase_b_i;
      if (!strobe_i) used <= 3'h0;
      else if (sb && !phase_b_i) used <= used + 3'h1;
      if (strobe_i && !rnw_i) mem[addr_i[3:0]] <= wdata_i;
      if (strobe_i && rnw_i) last <= rdata_o;
   end
   // Read data held through waits, scrambled once released
   assign rdata_o = (strobe_i && rnw_i) ? mem[addr_i[3:0]] : ~last;
   assign rpar_o = {~^rdata_o[15:8], ~^rdata_o[7:0]} ^ {1'b0, bad_par_i};
endmodule

// ---- sim/testbench.sv ----
// Self-checking bench for the local bus wait-state controller
`timescale 1ns/1ps
module testbench;
   logic sys_clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   lbus_pkg::bus_req_t req_i = '0;
   lbus_pkg::bus_rsp_t rsp_o;
   logic ext_rom_sel_i = 1'b0, irq_i = 1'b0, bus_req_i = 1'b0, slow_slave_wait_i = 1'b0;
   logic req_ready_o, int_rom_en_o, irq_take_o, bus_grant_o, hold_state_o, pull, pe;
   logic local_bus_ready_n_i, local_bus_ready_n_o, local_bus_ready_n_oe_o, data_oe_o;
   logic [15:0] addr_o, data_o, data_i, rd;
   logic [1:0] addr_par_o, data_par_o, data_par_i;
   logic local_read_not_write_o, local_bus_enable_strobe_o, exp_ram_cs_n_o;
   logic local_bus_clock_phase_a_o, local_bus_clock_phase_b_o, xcvr_dir_o, xcvr_en_n_o;
   logic ram_we_n_o, bad_par = 1'b0;
   logic [7:0] wait_count_o;
   logic [2:0] waits = 3'h0;
   int num_errors = 0, checks_done = 0, lat;
   always #12.5 sys_clk_i = ~sys_clk_i;
   // Open-drain ready with pull-up
   assign local_bus_ready_n_i = ~(pull | (local_bus_ready_n_oe_o & ~local_bus_ready_n_o));
   local_bus_wait_state_control DUT (.sys_clk_i, .rst_b_i, .req_i, .rsp_o, .req_ready_o,
      .ext_rom_sel_i, .int_rom_en_o, .irq_i, .bus_req_i, .irq_take_o, .bus_grant_o,
      .hold_state_o, .local_bus_ready_n_i, .local_bus_ready_n_o, .local_bus_ready_n_oe_o,
      .slow_slave_wait_i, .addr_o, .addr_par_o, .data_o, .data_par_o, .data_oe_o, .data_i,
      .data_par_i, .local_read_not_write_o, .local_bus_enable_strobe_o,
      .local_bus_clock_phase_a_o, .local_bus_clock_phase_b_o, .exp_ram_cs_n_o, .xcvr_dir_o,
      .xcvr_en_n_o, .ram_we_n_o, .wait_count_o);
   lbus_mem_model PARTNER (.sys_clk_i, .waits_i(waits), .bad_par_i(bad_par), .addr_i(addr_o),
      .strobe_i(local_bus_enable_strobe_o), .rnw_i(local_read_not_write_o),
      .phase_b_i(local_bus_clock_phase_b_o), .wdata_i(data_o), .rdata_o(data_i),
      .rpar_o(data_par_i), .pull_o(pull));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic close_out;
      $display("Checks %0d, errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic xfer(input lbus_pkg::role_t ro, input logic rnw, input logic [14:0] a,
         input logic [15:0] wd, input logic [2:0] w);
      @(posedge sys_clk_i);
      waits <= w;
      req_i <= {1'b1, rnw, a, wd, ro};
      do @(posedge sys_clk_i); while (req_ready_o !== 1'b1);
      req_i.valid <= 1'b0;
      lat = 0;
      do begin
         @(posedge sys_clk_i);
         lat++;
      end while (rsp_o.done !== 1'b1 && lat < 200);
      rd = rsp_o.rdata;
      pe = rsp_o.par_err;
   endtask
   task automatic t_rw;
      xfer(lbus_pkg::ROLE_CP_MASTER, 1'b0, 15'h0003, 16'hbeef, 3'h0);
      chk(lat, 5);
      xfer(lbus_pkg::ROLE_CP_MASTER, 1'b1, 15'h0003, 16'h0000, 3'h0);
      chk(lat, 5);
      chk(rd, 16'hbeef);
      $display("t_rw finished");
   endtask
   task automatic t_waits;
      for (int w = 1; w < 4; w++) begin
         xfer(lbus_pkg::ROLE_CP_MASTER, 1'b1, 15'h4004 + 15'(w), 16'h0000, 3'(w));
         chk(lat, 5 + 4 * w);
         chk(rd, 16'h0f04 + 16'(w));
         chk(wait_count_o, 8'(w));
      end
      $display("t_waits finished");
   endtask
   task automatic t_own;
      slow_slave_wait_i <= 1'b1;
      xfer(lbus_pkg::ROLE_CP_MASTER, 1'b1, 15'h4006, 16'h0000, 3'h0);
      chk(lat, 9);
      chk(wait_count_o, 8'h01);
      chk(rd, 16'h0f06);
      xfer(lbus_pkg::ROLE_CP_MASTER, 1'b1, 15'h0006, 16'h0000, 3'h0);
      chk(lat, 5);
      slow_slave_wait_i <= 1'b0;
      $display("t_own finished");
   endtask
   task automatic t_roles;
      lbus_pkg::role_t ro[3] = '{lbus_pkg::ROLE_PH_MASTER, lbus_pkg::ROLE_EXT_MASTER_PH,
         lbus_pkg::ROLE_CP_INTERNAL};
      int ex[3] = '{5, 9, 5};
      for (int i = 0; i < 3; i++) begin
         xfer(ro[i], 1'b1, 15'h4008, 16'h0000, 3'(2 - i));
         chk(lat, ex[i]);
      end
      $display("t_roles finished");
   endtask
   task automatic t_par;
      bad_par <= 1'b1;
      xfer(lbus_pkg::ROLE_CP_MASTER, 1'b1, 15'h0009, 16'h0000, 3'h0);
      chk(pe, 1'b1);
      bad_par <= 1'b0;
      xfer(lbus_pkg::ROLE_CP_MASTER, 1'b1, 15'h0009, 16'h0000, 3'h0);
      chk(pe, 1'b0);
      $display("t_par finished");
   endtask
   task automatic t_irq;
      int n = 0;
      fork
         xfer(lbus_pkg::ROLE_CP_MASTER, 1'b1, 15'h4002, 16'h0000, 3'h2);
         begin
            repeat (6) @(posedge sys_clk_i);
            irq_i <= 1'b1;
            do begin
               @(posedge sys_clk_i);
               n++;
            end while (irq_take_o !== 1'b1 && n < 40);
            irq_i <= 1'b0;
            chk(hold_state_o, 1'b0);
            chk(n > 4 && n < 40, 1'b1);
         end
      join
      $display("t_irq finished");
   endtask
   task automatic t_grant;
      int n = 0;
      bus_req_i <= 1'b1;
      do begin
         @(posedge sys_clk_i);
         n++;
      end while (bus_grant_o !== 1'b1 && n < 20);
      chk(n < 20, 1'b1);
      bus_req_i <= 1'b0;
      repeat (3) @(posedge sys_clk_i);
      chk(bus_grant_o, 1'b0);
      $display("t_grant finished");
   endtask
   task automatic t_strap;
      ext_rom_sel_i <= 1'b1;
      repeat (3) @(posedge sys_clk_i);
      chk(int_rom_en_o, 1'b0);
      ext_rom_sel_i <= 1'b0;
      repeat (3) @(posedge sys_clk_i);
      chk(int_rom_en_o, 1'b1);
      $display("t_strap finished");
   endtask
   initial begin
      repeat (8) @(posedge sys_clk_i);
      rst_b_i <= 1'b1;
      t_rw();
      t_waits();
      t_own();
      t_roles();
      t_par();
      t_irq();
      t_grant();
      t_strap();
      close_out();
   end
   initial begin
      repeat (4000) @(posedge sys_clk_i);
      num_errors++;
      close_out();
   end
endmodule
